//--- core/pige_top.sv
// Port interrupt enable register with APB slave and interrupt gating.
// Assumes status conditions arrive as levels from the port logic, synchronous to i_clk_sys.
// How it works
// - Interrupt when enable, status, global enable
// - Disabled conditions still visible in status
// - Enable and status share one layout
// - Bit 31 cold presence, optional read-only zero in enable only
// - Bit 30 gates task file error
// - Bits 29, 28 gate host bus errors
// - Bits 27, 26 gate link errors
// - Bit 23 gates wrong multiplier
// - Bit 22 gates link ready change
// - Bit 7 mechanical presence, optional read-only zero in enable only
// - Bit 6 gates connect change
// - Bit 5 gates descriptor done
// - Bit 4 gates unknown frame
// - Bits 3, 2 gate device bits, DMA setup
// - Bits 1, 0 gate PIO setup, D2H register
//
// Added by the designer: the APB slave port.
`timescale 1ns/1ps
`include "pige_regs.svh"
module pige_top #(
    parameter bit HAS_COLD_PRESENCE = 1'b1,
    parameter bit HAS_MECH_PRESENCE = 1'b1
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_pwdata,
    input wire logic [3:0] i_pstrb,
    input wire logic [31:0] i_port_status,
    output logic [31:0] o_prdata,
    output logic o_pready,
    output logic o_pslverr,
    output logic o_port_irq
);
    logic rst_meta_ff;
    logic rst_sync_ff;
    logic [31:0] enable_ff;
    logic [31:0] status_ff;
    logic global_ie_ff;
    logic [31:0] pending;
    logic gate_irq;
    logic [31:0] wmask;
    logic [31:0] bytemask;
    logic [31:0] nxt_prdata;
    logic nxt_pslverr;
    logic access;
    logic wr_commit;
    pige_pkg::pige_apb_req_t req;
    pige_pkg::pige_apb_state_t state_ff;

    assign req = '{psel: i_psel, penable: i_penable, pwrite: i_pwrite,
                   paddr: i_paddr, pwdata: i_pwdata};

    // Reset released through two flops so release is clean on i_clk_sys
    always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
        if (!i_rst_b) begin
            rst_meta_ff <= 1'b0;
            rst_sync_ff <= 1'b0;
        end else begin
            rst_meta_ff <= 1'b1;
            rst_sync_ff <= rst_meta_ff;
        end
    end

    // Optional sources become read-only zero in enable by removing them from its write mask; status still shows them
    always_comb begin
        wmask = `PIGE_WRITABLE_MASK;
        wmask[`PIGE_BIT_COLD_PRESENCE] = HAS_COLD_PRESENCE;
        wmask[`PIGE_BIT_MECH_PRESENCE] = HAS_MECH_PRESENCE;
    end

    generate
        for (genvar gb = 0; gb < 4; gb++) begin : g_strb
            assign bytemask[gb*8 +: 8] = {8{i_pstrb[gb]}};
        end
    endgenerate

    // Zero-wait slave: answer comes with the first access cycle
    always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            state_ff <= pige_pkg::PIGE_IDLE;
        end else if (req.psel && !req.penable) begin
            state_ff <= pige_pkg::PIGE_ACCESS;
        end else begin
            state_ff <= pige_pkg::PIGE_IDLE;
        end
    end

    assign access = req.psel && !req.penable;

    // Writes land on the edge that ends the access phase, where the master sees pready
    assign wr_commit = (state_ff == pige_pkg::PIGE_ACCESS) && req.psel && req.penable
                       && req.pwrite;

    // Enable register
    always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            enable_ff <= `PIGE_ENABLE_RESET;
        end else if (wr_commit && req.paddr == `PIGE_OFS_ENABLE) begin
            // Reserved and unsupported bits keep zero whatever is written
            enable_ff <= ((req.pwdata & bytemask) | (enable_ff & ~bytemask)) & wmask;
        end
    end

    // Adapter-wide enable, held here since no global register reaches this block
    always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            global_ie_ff <= 1'b0;
        end else if (wr_commit && req.paddr == `PIGE_OFS_CONFIG && i_pstrb[0]) begin
            global_ie_ff <= req.pwdata[`PIGE_CONFIG_IE_BIT];
        end
    end

    // Status is sampled regardless of enable so software always sees it
    always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            status_ff <= 32'h0000_0000;
        end else begin
            status_ff <= i_port_status & `PIGE_WRITABLE_MASK;
        end
    end

    // Bits 31..0 of enable gate the same positions of status
    pige_gate #(
        .WIDTH(32)
    ) u_gate (
        .i_clk_sys(i_clk_sys),
        .i_rst_sync_b(rst_sync_ff),
        .i_enable(enable_ff),
        .i_status(status_ff),
        .i_global_ie(global_ie_ff),
        .o_pending(pending),
        .o_irq(gate_irq)
    );

    always_comb begin
        nxt_prdata = 32'h0000_0000;
        nxt_pslverr = 1'b0;
        unique case (req.paddr)
            `PIGE_OFS_ENABLE: nxt_prdata = enable_ff;
            `PIGE_OFS_STATUS: nxt_prdata = status_ff;
            `PIGE_OFS_CONFIG: nxt_prdata = {31'h0000_0000, global_ie_ff};
            `PIGE_OFS_PENDING: nxt_prdata = pending;
            default: nxt_pslverr = 1'b1;
        endcase
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            o_prdata <= 32'h0000_0000;
            o_pready <= 1'b0;
            o_pslverr <= 1'b0;
        end else begin
            o_pready <= access;
            o_pslverr <= access && nxt_pslverr;
            o_prdata <= (access && !req.pwrite) ? nxt_prdata : 32'h0000_0000;
        end
    end

    always_ff @(posedge i_clk_sys or negedge rst_sync_ff) begin
        if (!rst_sync_ff) begin
            o_port_irq <= 1'b0;
        end else begin
            o_port_irq <= gate_irq;
        end
    end
endmodule

//--- common/pige_regs.svh
// Register offsets, field positions and reset values of the port interrupt enable block.
// Assumes a 32-bit APB register space, one aligned word per register.
`ifndef PIGE_REGS_SVH
`define PIGE_REGS_SVH

`define PIGE_OFS_ENABLE 12'h014
`define PIGE_OFS_STATUS 12'h010
`define PIGE_OFS_CONFIG 12'h040
`define PIGE_OFS_PENDING 12'h044

`define PIGE_BIT_COLD_PRESENCE 31
`define PIGE_BIT_TASK_FILE_ERROR 30
`define PIGE_BIT_HOST_BUS_FATAL 29
`define PIGE_BIT_HOST_BUS_DATA 28
`define PIGE_BIT_LINK_FATAL 27
`define PIGE_BIT_LINK_NONFATAL 26
`define PIGE_BIT_RECEIVE_OVERFLOW 24
`define PIGE_BIT_WRONG_MULTIPLIER 23
`define PIGE_BIT_LINK_READY_CHANGE 22
`define PIGE_BIT_MECH_PRESENCE 7
`define PIGE_BIT_CONNECT_CHANGE 6
`define PIGE_BIT_DESCRIPTOR_DONE 5
`define PIGE_BIT_UNKNOWN_FRAME 4
`define PIGE_BIT_DEVICE_BITS_FRAME 3
`define PIGE_BIT_DMA_SETUP_FRAME 2
`define PIGE_BIT_PIO_SETUP_FRAME 1
`define PIGE_BIT_D2H_REGISTER_FRAME 0

`define PIGE_WRITABLE_MASK 32'hFDC0_00FF
`define PIGE_ENABLE_RESET 32'h0000_0000
`define PIGE_CONFIG_IE_BIT 0

`endif

//--- common/pige_pkg.sv
// Types shared by the port interrupt enable block.
// Assumes the register header is included by the design files.
package pige_pkg;

    typedef struct packed {
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [11:0] paddr;
        logic [31:0] pwdata;
    } pige_apb_req_t;

    typedef struct packed {
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pige_apb_rsp_t;

    typedef enum logic [1:0] {
        PIGE_IDLE,
        PIGE_ACCESS
    } pige_apb_state_t;

endpackage

//--- core/pige_gate.sv
// Per-bit gating of status by enable and the adapter-wide enable.
// Assumes all inputs are synchronous to i_clk_sys; output is registered.
`timescale 1ns/1ps
module pige_gate #(
    parameter int WIDTH = 32
) (
    input wire logic i_clk_sys,
    input wire logic i_rst_sync_b,
    input wire logic [WIDTH-1:0] i_enable,
    input wire logic [WIDTH-1:0] i_status,
    input wire logic i_global_ie,
    output logic [WIDTH-1:0] o_pending,
    output logic o_irq
);
    logic [WIDTH-1:0] nxt_pending;

    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_bit
            // One gate per condition, same position in both registers
            assign nxt_pending[gi] = i_enable[gi] & i_status[gi] & i_global_ie;
        end
    endgenerate

    always_ff @(posedge i_clk_sys or negedge i_rst_sync_b) begin
        if (!i_rst_sync_b) begin
            o_pending <= '0;
            o_irq <= 1'b0;
        end else begin
            o_pending <= nxt_pending;
            o_irq <= |nxt_pending;
        end
    end
endmodule

//--- verification/pige_top_asserts.sv
// Checker on the port interrupt enable top ports.
// Assumes APB setup then a one-cycle answer, as in the hand-over contract.
`timescale 1ns/1ps
module pige_top_asserts (
    input wire logic i_clk_sys,
    input wire logic i_rst_b,
    input wire logic i_psel,
    input wire logic i_penable,
    input wire logic i_pwrite,
    input wire logic [11:0] i_paddr,
    input wire logic [31:0] i_port_status,
    input wire logic [31:0] o_prdata,
    input wire logic o_pready,
    input wire logic o_pslverr,
    input wire logic o_port_irq
);
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_b);
    wire logic set_up = i_psel && !i_penable;
    wire logic known = i_paddr inside {12'h010, 12'h014, 12'h040, 12'h044};
    // Five quiet samples cover the three-edge irq path with margin
    sequence s_quiet; ((i_port_status & 32'hFDC0_00FF) == 32'h0000_0000) [*5]; endsequence
    property p_ready; set_up |=> o_pready; endproperty
    a_ready: assert property (p_ready) else $error("no ready after setup");
    property p_pulse; o_pready |=> !o_pready; endproperty
    a_pulse: assert property (p_pulse) else $error("ready held");
    property p_err; o_pslverr |-> o_pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_unmapped; set_up && !known |=> o_pslverr && o_prdata == 32'h0000_0000; endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped not refused");
    property p_idle; !o_pready |-> o_prdata == 32'h0000_0000; endproperty
    a_idle: assert property (p_idle) else $error("read data outside access");
    property p_resv; set_up && !i_pwrite && i_paddr == 12'h014
        |=> (o_prdata & 32'h023F_FF00) == 32'h0000_0000; endproperty
    a_resv: assert property (p_resv) else $error("reserved bit read one");
    property p_cause; s_quiet |-> !o_port_irq; endproperty
    a_cause: assert property (p_cause) else $error("irq without status");
    property p_rst; $rose(i_rst_b) |-> !o_port_irq [*3]; endproperty
    a_rst: assert property (p_rst) else $error("irq after reset");
endmodule
bind pige_top pige_top_asserts i_chk (.*);

//--- verification/pige_status_model.sv
// Port logic stand-in that holds status condition levels.
// Assumes the bench requests a new set between edges.
`timescale 1ns/1ps
module pige_status_model (
    input wire logic i_clk_sys,
    input wire logic [31:0] i_set,
    output logic [31:0] o_port_status
);
    // Registered so levels only move after an edge, as real port logic does
    always_ff @(posedge i_clk_sys) begin
        o_port_status <= i_set;
    end
endmodule

//--- verification/port_interrupt_enable_gating_bench.sv
// Bench: APB master, gating rows, per-bit walk, refusals and mid-run reset.
// Assumes the status model feeds the conditions.
`timescale 1ns/1ps
`include "pige_regs.svh"
module port_interrupt_enable_gating_bench;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0000_0000;
    logic [31:0] st_set = 32'h0000_0000;
    logic [3:0] pstrb = 4'hF;
    logic [31:0] status, prdata, rd, en, st;
    logic pready, pslverr, irq, err, ie, ex;
    int errors = 0;
    int total_checks = 0;
    int cycles = 0;
    int bits[17] = '{31, 30, 29, 28, 27, 26, 24, 23, 22, 7, 6, 5, 4, 3, 2, 1, 0};
    // Enable, status, global enable, expected irq
    logic [65:0] rows[5] = '{{32'hFDC0_00FF, 32'hFDC0_00FF, 2'h3},
        {32'hFFFF_FFFF, 32'h0000_0000, 2'h2}, {32'h0000_0001, 32'h0000_0002, 2'h2},
        {32'hFDC0_00FF, 32'hFDC0_00FF, 2'h0}, {32'hFFFF_FFFF, 32'h023F_FF00, 2'h2}};
    always #4 clk = ~clk;
    pige_status_model i_model (.i_clk_sys(clk), .i_set(st_set), .o_port_status(status));
    pige_top i_dut (.i_clk_sys(clk), .i_rst_b(rst_b), .i_psel(psel), .i_penable(penable),
        .i_pwrite(pwrite), .i_paddr(paddr), .i_pwdata(pwdata), .i_pstrb(pstrb),
        .i_port_status(status), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .o_port_irq(irq));
    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, errors);
        if (errors == 0 && total_checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            errors++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task automatic xfer(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        // No wait count is assumed; only the bench timeout ends a stalled access
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Irq path is three edges; six leave margin and end on a rising edge
    task automatic settle();
        repeat (6) @(posedge clk);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles > 3000) begin
            errors++;
            report_and_stop();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, `PIGE_OFS_ENABLE, 32'h0000_0000);
        chk("enable reset", 32'h0000_0000, rd);
        for (int i = 0; i < 5; i++) begin
            {en, st, ie, ex} = rows[i];
            xfer(1'b1, `PIGE_OFS_ENABLE, en);
            xfer(1'b1, `PIGE_OFS_CONFIG, {31'h0, ie});
            st_set <= st;
            settle();
            chk("irq row", {31'h0, ex}, {31'h0, irq});
        end
        for (int i = 0; i < 17; i++) begin
            st_set <= 32'h0000_0001 << bits[i];
            xfer(1'b1, `PIGE_OFS_ENABLE, 32'h0000_0001 << bits[i]);
            settle();
            chk("irq bit", 32'h0000_0001, {31'h0, irq});
            xfer(1'b1, `PIGE_OFS_ENABLE, 32'hFDC0_00FF ^ (32'h0000_0001 << bits[i]));
            settle();
            chk("irq masked", 32'h0000_0000, {31'h0, irq});
            xfer(1'b0, `PIGE_OFS_STATUS, 32'h0000_0000);
            chk("status seen", 32'h0000_0001 << bits[i], rd);
        end
        xfer(1'b1, `PIGE_OFS_ENABLE, 32'hFFFF_FFFF);
        xfer(1'b0, `PIGE_OFS_ENABLE, 32'h0000_0000);
        chk("enable back", 32'hFDC0_00FF, rd);
        // Lane strobes: config ignores a write without lane 0, enable keeps unstrobed lanes
        pstrb <= 4'hE;
        xfer(1'b1, `PIGE_OFS_CONFIG, 32'h0000_0000);
        pstrb <= 4'h1;
        xfer(1'b1, `PIGE_OFS_ENABLE, 32'h0000_0000);
        pstrb <= 4'hF;
        xfer(1'b0, `PIGE_OFS_ENABLE, 32'h0000_0000);
        chk("enable lanes", 32'hFDC0_0000, rd);
        xfer(1'b0, `PIGE_OFS_CONFIG, 32'h0000_0000);
        chk("config lane", 32'h0000_0001, rd);
        xfer(1'b1, 12'h020, 32'hFFFF_FFFF);
        chk("slverr", 32'h0000_0001, {31'h0, err});
        xfer(1'b0, 12'h020, 32'h0000_0000);
        chk("unmapped", 32'h0000_0000, rd);
        st_set <= 32'hFFFF_FFFF;
        settle();
        chk("irq all", 32'h0000_0001, {31'h0, irq});
        xfer(1'b0, `PIGE_OFS_PENDING, 32'h0000_0000);
        chk("pending", 32'hFDC0_0000, rd);
        xfer(1'b0, `PIGE_OFS_STATUS, 32'h0000_0000);
        chk("status all", 32'hFDC0_00FF, rd);
        rst_b <= 1'b0;
        repeat (2) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        xfer(1'b0, `PIGE_OFS_ENABLE, 32'h0000_0000);
        chk("enable rerst", 32'h0000_0000, rd);
        chk("irq rerst", 32'h0000_0000, {31'h0, irq});
        report_and_stop();
    end
endmodule
